// ==== core/pt_timer.sv ====
// Periodic timer: prescaled 16-bit modulo up-counter with wrap flag and interrupt request.
// Assumes an Avalon-MM master on clk, synchronous wait, stop and break inputs from the system.
//
// Notes on behaviour
// - Three-bit select picks bus clock divided by 1..64; code 7 also 64; reset clears.
// - Count equal to modulo sets wrap flag and restarts at zero next tick.
// - Flag clears by status read seeing it set, then writing 0; new wrap cancels.
// - Interrupt request while wrap flag and its enable are both one.
// - Halt bit holds the counter; reset sets it.
// - Writing count_clear clears counter, prescaler and low-byte latch; bit reads zero.
// - Halt and clear written together leave counter stopped at zero.
// - High count read latches low byte until low byte read releases it.
// - Count registers are read-only, cleared by reset and by count_clear.
// - Modulo high write inhibits flag and interrupt until modulo low written.
// - Modulo registers read and write, reset to all ones.
// - In wait mode counting continues, bus access blocked, enabled interrupt wakes.
// - In stop mode the timer freezes and keeps all state.
// - Break state holds the counter.
// - Break-clear enable lets status bits clear in break; otherwise unchanged.
// - Two-step clear started before break completes after break when protected.
// - Sixteen-bit free-running or modulo counter, readable without disturbance.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module pt_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire pt_pkg::pt_bus_req_t bus_req,
  output pt_pkg::pt_bus_rsp_t bus_rsp,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic break_clear_enable,
  output logic wrap_irq,
  output logic wake_request
);

  // Width of the free-running prescaler; its low bits form the seven taps.
  localparam int PT_W = pt_pkg::PT_PRESCALE_BITS;

  // Control and status state.
  logic [2:0] prescale_select;
  logic wrap_flag;
  logic wrap_irq_enable;
  logic count_halt;
  logic clear_armed;
  logic [PT_W-1:0] prescaler;
  logic [15:0] count;
  logic [7:0] low_latch;
  logic latch_held;
  logic [7:0] modulo_high;
  logic [7:0] modulo_low;
  logic modulo_pending;
  logic rd_pending;
  logic [31:0] rd_data;

  // Decoding of the bus request. Registers are unreachable in wait mode and in stop mode.
  // A blocked access is stalled rather than refused, so the master never loses a transfer.
  wire bus_blocked = wait_mode | stop_mode;
  wire [4:0] addr = bus_req.address;
  // Full byte-address compare, so an unmapped address selects nothing and reads zero.
  wire sel_sc = addr == pt_pkg::PT_OFS_STATUS_CONTROL;
  wire sel_ch = addr == pt_pkg::PT_OFS_COUNT_HIGH;
  wire sel_cl = addr == pt_pkg::PT_OFS_COUNT_LOW;
  wire sel_mh = addr == pt_pkg::PT_OFS_MODULO_HIGH;
  wire sel_ml = addr == pt_pkg::PT_OFS_MODULO_LOW;
  wire rd_go = bus_req.read & ~rd_pending & ~bus_blocked;
  wire wr_go = bus_req.write & ~bus_blocked;
  wire [7:0] wbyte = bus_req.writedata[7:0];
  wire wr_sc = wr_go & sel_sc;
  wire wr_clear = wr_sc & wbyte[pt_pkg::PT_BIT_COUNT_CLEAR];
  wire wr_halt = wbyte[pt_pkg::PT_BIT_COUNT_HALT];
  // Status bits may only change in break when the break-clear enable is set.
  wire status_ok = ~break_active | break_clear_enable;

  // Prescaler taps: tap n is high once every 2**n bus clocks; codes 6 and 7 both take tap 6.
  function automatic logic tap_hit(input logic [2:0] sel, input logic [PT_W-1:0] pre);
    logic [PT_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < PT_W; i++)
      if (i < int'(sel))
        mask[i] = 1'b1;
    return (pre & mask) == mask;
  endfunction
  wire tick = tap_hit(prescale_select, prescaler);

  // Counter advances only when running, not frozen by stop mode, and not in break.
  wire run = ~count_halt & ~stop_mode & ~break_active;
  wire [15:0] modulo = {modulo_high, modulo_low};
  wire at_modulo = count == modulo;
  wire wrap_event = run & tick & at_modulo & ~modulo_pending;
  wire [15:0] next_count = at_modulo ? 16'h0000 : count + 16'h0001;
  wire flag_clear = wr_sc & ~wbyte[pt_pkg::PT_BIT_WRAP_FLAG] & clear_armed & status_ok;

  // Read data mux; the clear bit always reads back as zero.
  wire [7:0] sc_view = {wrap_flag, wrap_irq_enable, count_halt, 1'b0, 1'b0, prescale_select};
  wire [7:0] rd_byte = sel_sc ? sc_view :
                       sel_ch ? count[15:8] :
                       sel_cl ? (latch_held ? low_latch : count[7:0]) :
                       sel_mh ? modulo_high :
                       sel_ml ? modulo_low : 8'h00;

  // Prescaler runs freely except in stop mode; count_clear restarts it.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prescaler <= '0;
    else if (wr_clear)
      prescaler <= '0;
    else if (~stop_mode)
      prescaler <= prescaler + 1'b1;
  end

  // Counter: clear has priority, so halt plus clear leaves it at zero.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count <= pt_pkg::PT_RST_COUNT;
    else if (wr_clear)
      count <= 16'h0000;
    else if (run && tick)
      count <= next_count;
  end

  // Control fields of the status register.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prescale_select <= pt_pkg::PT_RST_PRESCALE;
      wrap_irq_enable <= 1'b0;
      count_halt <= pt_pkg::PT_RST_COUNT_HALT;
    end
    else if (wr_sc)
    begin
      prescale_select <= wbyte[2:0];
      wrap_irq_enable <= wbyte[pt_pkg::PT_BIT_WRAP_IRQ_ENABLE];
      count_halt <= wr_halt;
    end
  end

  // Wrap flag: a new wrap wins over a clear and disarms the clear sequence.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrap_flag <= 1'b0;
      clear_armed <= 1'b0;
    end
    else
    begin
      if (wrap_event)
        wrap_flag <= 1'b1;
      else if (flag_clear)
        wrap_flag <= 1'b0;
      if (wrap_event || flag_clear)
        clear_armed <= 1'b0;
      else if (rd_go && sel_sc && wrap_flag)
        clear_armed <= 1'b1;
    end
  end

  // Low-byte latch for coherent 16-bit reads.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_latch <= 8'h00;
      latch_held <= 1'b0;
    end
    else if (wr_clear)
    begin
      low_latch <= 8'h00;
      latch_held <= 1'b0;
    end
    else if (rd_go && sel_ch && !latch_held)
    begin
      low_latch <= count[7:0];
      latch_held <= 1'b1;
    end
    else if (rd_go && sel_cl)
      latch_held <= 1'b0;
  end

  // Modulo registers and the high-then-low inhibit.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modulo_high <= pt_pkg::PT_RST_MODULO_BYTE;
      modulo_low <= pt_pkg::PT_RST_MODULO_BYTE;
      modulo_pending <= 1'b0;
    end
    else if (wr_go && sel_mh)
    begin
      modulo_high <= wbyte;
      modulo_pending <= 1'b1;
    end
    else if (wr_go && sel_ml)
    begin
      modulo_low <= wbyte;
      modulo_pending <= 1'b0;
    end
  end

  // Bus answer: writes finish at once, reads take one wait cycle for registered data.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_pending <= 1'b0;
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      rd_pending <= rd_go;
      if (rd_go)
        rd_data <= {24'h00_0000, rd_byte};
    end
  end

  // Interrupt and wake outputs, registered.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrap_irq <= 1'b0;
      wake_request <= 1'b0;
    end
    else
    begin
      wrap_irq <= wrap_flag & wrap_irq_enable & ~modulo_pending;
      wake_request <= wrap_flag & wrap_irq_enable & ~modulo_pending & wait_mode;
    end
  end

  // Waitrequest is high during a blocked access and during the first read cycle.
  assign bus_rsp.waitrequest = ((bus_req.read | bus_req.write) & bus_blocked) | (bus_req.read & ~rd_pending);
  assign bus_rsp.readdata = rd_data;

  // The checks below watch what this module drives. They are off while reset is low,
  // because every register is forced then and no rule speaks about that interval.

  // A wrap is the cycle in which the counter sits on the modulo and the selected tap fires.
  sequence at_wrap_s;
    wrap_event;
  endsequence

  // A status read that sees the flag set is the first half of the two-step clear.
  sequence arm_read_s;
    rd_go && sel_sc && wrap_flag && !wrap_event;
  endsequence

  // The second half is a status write with the flag bit low while the sequence is armed.
  sequence clear_write_s;
    wr_sc && !wbyte[pt_pkg::PT_BIT_WRAP_FLAG] && clear_armed && status_ok && !wrap_event;
  endsequence

  // Wrap at modulo sets the flag and zeroes the counter.
  wrap_sets_a: assert property (@(posedge clk) disable iff (!arst_n) at_wrap_s |=> wrap_flag && count == 16'h0000 || wr_clear)
    else $error("wrap did not set flag or zero counter");

  // A stopped counter keeps its value; only the clear bit may move it.
  halt_holds_a: assert property (@(posedge clk) disable iff (!arst_n) count_halt && !wr_clear |=> $stable(count))
    else $error("counter moved while halted");

  // A break holds the counter just as the halt bit does.
  break_holds_a: assert property (@(posedge clk) disable iff (!arst_n) break_active && !wr_clear |=> $stable(count))
    else $error("counter moved in break");

  // The clear bit empties both the counter and the prescaler in one cycle.
  clear_zero_a: assert property (@(posedge clk) disable iff (!arst_n) wr_clear |=> count == 16'h0000 && prescaler == '0)
    else $error("clear left counter or prescaler nonzero");

  // Halt and clear together leave the counter parked at zero in the following cycles too.
  halt_clear_a: assert property (@(posedge clk) disable iff (!arst_n) wr_clear && wr_halt |=> count == 16'h0000 ##1 count == 16'h0000)
    else $error("halt with clear did not stay at zero");

  // The interrupt is a registered copy, so it looks one cycle back at flag and enable.
  irq_level_a: assert property (@(posedge clk) disable iff (!arst_n) wrap_irq |-> $past(wrap_flag) && $past(wrap_irq_enable))
    else $error("interrupt without flag and enable");

  // The flag may only fall at the end of a complete and permitted clear sequence.
  flag_clear_a: assert property (@(posedge clk) disable iff (!arst_n) $fell(wrap_flag) |-> $past(clear_armed) && $past(status_ok))
    else $error("flag cleared without armed sequence");

  // While the modulo high byte waits for its low byte, no wrap may raise the flag.
  inhibit_a: assert property (@(posedge clk) disable iff (!arst_n) modulo_pending && !wrap_flag |=> !wrap_flag)
    else $error("flag set during modulo inhibit");

  // A held low-byte copy changes only through a low-byte read or the clear bit.
  latch_keep_a: assert property (@(posedge clk) disable iff (!arst_n) latch_held && !wr_clear && !(rd_go && sel_cl) |=> $stable(low_latch))
    else $error("latched low byte changed");

  // A read that sees the flag set arms the clear, unless a wrap lands in the same cycle.
  arm_read_a: assert property (@(posedge clk) disable iff (!arst_n) arm_read_s |=> clear_armed)
    else $error("status read did not arm the flag clear");

  // A complete clear sequence drops the flag in the next cycle.
  clear_done_a: assert property (@(posedge clk) disable iff (!arst_n) clear_write_s |=> !wrap_flag)
    else $error("armed clear write left the flag set");

  // A wrap always wins over a clear in the same cycle and disarms the sequence.
  set_wins_a: assert property (@(posedge clk) disable iff (!arst_n) at_wrap_s |=> wrap_flag && !clear_armed)
    else $error("wrap lost against a clear");

  // With break protection on, a set flag survives every access made during the break.
  break_keep_a: assert property (@(posedge clk) disable iff (!arst_n) break_active && !break_clear_enable && wrap_flag |=> wrap_flag)
    else $error("flag changed in a protected break");

  // Flag and enable raise the interrupt one cycle later when no modulo write is pending.
  irq_follow_a: assert property (@(posedge clk) disable iff (!arst_n) wrap_flag && wrap_irq_enable && !modulo_pending |=> wrap_irq)
    else $error("interrupt missing with flag and enable set");

  // In wait mode the same condition also asks the processor to wake.
  wake_follow_a: assert property (@(posedge clk) disable iff (!arst_n) wrap_flag && wrap_irq_enable && !modulo_pending && wait_mode |=> wake_request)
    else $error("wake request missing in wait mode");

  // No wake request is raised outside wait mode.
  wake_only_a: assert property (@(posedge clk) disable iff (!arst_n) !wait_mode |=> !wake_request)
    else $error("wake request outside wait mode");

  // Wait and stop hold off every bus access; the master simply sees a stall.
  blocked_wait_a: assert property (@(posedge clk) disable iff (!arst_n) (bus_req.read || bus_req.write) && bus_blocked |-> bus_rsp.waitrequest)
    else $error("bus access answered in wait or stop mode");

  // The timer keeps running in wait mode: the prescaler steps on every bus clock.
  wait_runs_a: assert property (@(posedge clk) disable iff (!arst_n) wait_mode && !stop_mode |=> prescaler != $past(prescaler))
    else $error("prescaler idle in wait mode");

  // Stop mode freezes the prescaler as well as the counter.
  stop_freeze_a: assert property (@(posedge clk) disable iff (!arst_n) stop_mode |=> $stable(prescaler) && $stable(count))
    else $error("timer moved in stop mode");

  // A read answers after exactly one wait cycle, unless the bus is blocked meanwhile.
  read_answer_a: assert property (@(posedge clk) disable iff (!arst_n) rd_go |=> !bus_rsp.waitrequest || !bus_req.read || bus_blocked)
    else $error("read not answered after one wait cycle");

  // The clear bit is write-only and never shows in read data.
  clear_reads_zero_a: assert property (@(posedge clk) disable iff (!arst_n) rd_go && sel_sc |=> rd_data[pt_pkg::PT_BIT_COUNT_CLEAR] == 1'b0)
    else $error("clear bit visible in read data");

  // A high-byte modulo write opens the inhibit.
  modulo_open_a: assert property (@(posedge clk) disable iff (!arst_n) wr_go && sel_mh |=> modulo_pending)
    else $error("modulo high write did not inhibit");

  // A low-byte modulo write closes the inhibit.
  modulo_close_a: assert property (@(posedge clk) disable iff (!arst_n) wr_go && sel_ml |=> !modulo_pending)
    else $error("modulo low write did not release inhibit");

  // A running counter below the modulo steps by exactly one per tick.
  step_one_a: assert property (@(posedge clk) disable iff (!arst_n) run && tick && !at_modulo && !wr_clear |=> count == $past(count) + 16'h0001)
    else $error("counter did not step by one");

  // Code 7 repeats the slowest division of code 6.
  slow_alias_a: assert property (@(posedge clk) disable iff (!arst_n) prescale_select == 3'h7 |-> tick == tap_hit(3'h6, prescaler))
    else $error("code 7 tick differs from code 6");

  // A first high-byte read captures the low byte and holds it.
  latch_take_a: assert property (@(posedge clk) disable iff (!arst_n) rd_go && sel_ch && !latch_held && !wr_clear |=> latch_held)
    else $error("high read did not latch the low byte");

endmodule

// ==== include/pt_pkg.sv ====
// Package for the periodic timer: register offsets, field positions, reset values and bus carriers.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package pt_pkg;

  // Byte addresses of the five registers.
  localparam logic [4:0] PT_OFS_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] PT_OFS_COUNT_HIGH = 5'h04;
  localparam logic [4:0] PT_OFS_COUNT_LOW = 5'h08;
  localparam logic [4:0] PT_OFS_MODULO_HIGH = 5'h0c;
  localparam logic [4:0] PT_OFS_MODULO_LOW = 5'h10;

  // Field positions inside timer_status_control.
  localparam int PT_BIT_WRAP_FLAG = 7;
  localparam int PT_BIT_WRAP_IRQ_ENABLE = 6;
  localparam int PT_BIT_COUNT_HALT = 5;
  localparam int PT_BIT_COUNT_CLEAR = 4;
  localparam int PT_LSB_PRESCALE = 0;

  // Values after reset.
  localparam logic [2:0] PT_RST_PRESCALE = 3'h0;
  localparam logic PT_RST_COUNT_HALT = 1'b1;
  localparam logic [7:0] PT_RST_MODULO_BYTE = 8'hff;
  localparam logic [15:0] PT_RST_COUNT = 16'h0000;

  // Prescaler depth: seven taps from divide by 1 to divide by 64.
  localparam int PT_PRESCALE_BITS = 6;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
  } pt_bus_req_t;

  // Avalon-MM answer from the slave.
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } pt_bus_rsp_t;

endpackage

// ==== bench/pt_timer_bench.sv ====
// Self-checking bench for the periodic timer: drives the Avalon-MM slave and the mode inputs directly.
// Assumes the timer module and its package are compiled first; no partner model is needed.
`timescale 1ns/10ps
module pt_timer_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  pt_pkg::pt_bus_req_t bus_req = '0;
  pt_pkg::pt_bus_rsp_t bus_rsp;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic break_active = 1'b0;
  logic break_clear_enable = 1'b0;
  logic wrap_irq;
  logic wake_request;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [7:0] va;
  localparam logic [4:0] A_ST = pt_pkg::PT_OFS_STATUS_CONTROL;
  localparam logic [4:0] A_CH = pt_pkg::PT_OFS_COUNT_HIGH;
  localparam logic [4:0] A_CL = pt_pkg::PT_OFS_COUNT_LOW;
  localparam logic [4:0] A_MH = pt_pkg::PT_OFS_MODULO_HIGH;
  localparam logic [4:0] A_ML = pt_pkg::PT_OFS_MODULO_LOW;
  localparam logic [4:0] A_BAD = 5'h14;

  // Free-running 20 MHz clock.
  always #25 clk = ~clk;

  pt_timer DUT (
    .clk(clk),
    .arst_n(arst_n),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .wait_mode(wait_mode),
    .stop_mode(stop_mode),
    .break_active(break_active),
    .break_clear_enable(break_clear_enable),
    .wrap_irq(wrap_irq),
    .wake_request(wake_request)
  );

  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compares one value with case equality so an unknown never matches.
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon transfer: held until waitrequest is sampled low at a rising edge, released there.
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    bus_req.read <= !wr;
    bus_req.write <= wr;
    bus_req.address <= a;
    bus_req.writedata <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
      begin
        miscompares++;
        finish_test;
      end
    end
    while (bus_rsp.waitrequest !== 1'b0);
    rd = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    @(posedge clk);
  endtask

  // Two low-byte reads 128 cycles apart, with a mode held for 100 of them in between.
  task delta(input logic [7:0] exp, input logic w, input logic s, input logic b);
    bus(1'b0, A_CL, 8'h00);
    va = rd[7:0];
    wait_mode <= w;
    stop_mode <= s;
    break_active <= b;
    repeat (100) @(posedge clk);
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
    break_active <= 1'b0;
    repeat (25) @(posedge clk);
    bus(1'b0, A_CL, 8'h00);
    chk("count step", {24'h0, exp}, {24'h0, rd[7:0] - va});
  endtask

  // Arms the flag clear before a break, then tries to finish it inside the break.
  task brk(input logic bce, input logic [7:0] exp);
    bus(1'b1, A_ST, 8'h50);
    repeat (30) @(posedge clk);
    bus(1'b1, A_ST, 8'he0);
    bus(1'b0, A_ST, 8'h00);
    chk("status armed", 32'he0, rd);
    break_active <= 1'b1;
    break_clear_enable <= bce;
    @(posedge clk);
    bus(1'b1, A_ST, 8'h60);
    bus(1'b0, A_ST, 8'h00);
    chk("status in break", {24'h0, exp}, rd);
    bus(1'b0, A_CH, 8'h00);
    bus(1'b0, A_CL, 8'h00);
    break_active <= 1'b0;
    @(posedge clk);
    bus(1'b1, A_ST, 8'h60);
    bus(1'b0, A_ST, 8'h00);
    chk("status after break", 32'h60, rd);
  endtask

  // Main sequence: reset values, prescaler, modes, latch, clear, wrap flag and break.
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, A_ST, 8'h00);
    chk("status reset", 32'h20, rd);
    bus(1'b0, A_CH, 8'h00);
    chk("count high reset", 32'h0, rd);
    bus(1'b0, A_MH, 8'h00);
    chk("modulo high reset", 32'hff, rd);
    bus(1'b0, A_ML, 8'h00);
    chk("modulo low reset", 32'hff, rd);
    bus(1'b0, A_BAD, 8'h00);
    chk("unmapped read", 32'h0, rd);
    chk("irq reset", 32'h0, {31'h0, wrap_irq});
    delta(8'h00, 1'b0, 1'b0, 1'b0);
    // Every select code, the last one repeating the slowest division.
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, A_ST, 8'h10 | 8'(c));
      delta(8'd128 >> (c == 7 ? 6 : c), 1'b0, 1'b0, 1'b0);
    end
    bus(1'b1, A_ST, 8'h00);
    delta(8'd128, 1'b1, 1'b0, 1'b0);
    delta(8'd28, 1'b0, 1'b1, 1'b0);
    delta(8'd28, 1'b0, 1'b0, 1'b1);
    // The low byte must keep the value captured by the first high read.
    bus(1'b0, A_CL, 8'h00);
    va = rd[7:0];
    repeat (125) @(posedge clk);
    bus(1'b0, A_CH, 8'h00);
    repeat (40) @(posedge clk);
    bus(1'b0, A_CH, 8'h00);
    bus(1'b0, A_CL, 8'h00);
    chk("latched low", {24'h0, va + 8'd128}, rd);
    bus(1'b1, A_ST, 8'h30);
    bus(1'b1, A_CH, 8'h55);
    bus(1'b0, A_CH, 8'h00);
    chk("count high cleared", 32'h0, rd);
    bus(1'b0, A_CL, 8'h00);
    chk("count low cleared", 32'h0, rd);
    bus(1'b0, A_ST, 8'h00);
    chk("clear bit reads 0", 32'h20, rd);
    bus(1'b0, A_MH, 8'h00);
    chk("modulo kept", 32'hff, rd);
    // A short modulo is written first, then the counter is cleared and started, wrapping every ten cycles.
    bus(1'b1, A_MH, 8'h00);
    bus(1'b1, A_ML, 8'h09);
    bus(1'b1, A_ST, 8'h50);
    repeat (30) @(posedge clk);
    chk("irq on wrap", 32'h1, {31'h0, wrap_irq});
    bus(1'b1, A_ST, 8'h40);
    bus(1'b0, A_ST, 8'h00);
    chk("write 0 unarmed", 32'hc0, rd);
    wait_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk("wake in wait", 32'h1, {31'h0, wake_request});
    wait_mode <= 1'b0;
    @(posedge clk);
    bus(1'b0, A_ST, 8'h00);
    repeat (20) @(posedge clk);
    bus(1'b1, A_ST, 8'h40);
    bus(1'b0, A_ST, 8'h00);
    chk("clear lost to wrap", 32'hc0, rd);
    bus(1'b1, A_ST, 8'he0);
    bus(1'b1, A_MH, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq inhibited", 32'h0, {31'h0, wrap_irq});
    bus(1'b1, A_ML, 8'h09);
    repeat (2) @(posedge clk);
    chk("irq released", 32'h1, {31'h0, wrap_irq});
    bus(1'b0, A_ST, 8'h00);
    chk("flag seen before clear", 32'he0, rd);
    bus(1'b1, A_ST, 8'h60);
    bus(1'b0, A_ST, 8'h00);
    chk("flag cleared", 32'h60, rd);
    chk("irq dropped", 32'h0, {31'h0, wrap_irq});
    brk(1'b0, 8'he0);
    brk(1'b1, 8'h60);
    finish_test;
  end
endmodule
